// >>> src/pslc_consts.svh
/*
  Constants of the synthesizer serial programming port: latch select codes,
  field positions, host register offsets, reset values and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PSLC_CONSTS_SVH
`define PSLC_CONSTS_SVH

`define PSLC_WORD_W 24
`define PSLC_SEL_CTRL 2'h0
`define PSLC_SEL_REF 2'h1
`define PSLC_SEL_FB 2'h2

`define PSLC_CTRL_CNT_RST 4
`define PSLC_CTRL_GAIN 10
`define PSLC_CTRL_PRESC_LSB 22

`define PSLC_FB_SWALLOW_LSB 2
`define PSLC_FB_SPARE 7
`define PSLC_FB_MAIN_LSB 8
`define PSLC_FB_GAIN 21
`define PSLC_FB_DIV2 22
`define PSLC_FB_HALF_SRC 23
`define PSLC_MAIN_MIN 13'h0003

`define PSLC_REF_RATIO_LSB 2
`define PSLC_REF_ABP_LSB 16
`define PSLC_REF_LOCK_PREC 18
`define PSLC_REF_TEST 19
`define PSLC_REF_BSC_LSB 20
`define PSLC_REF_SPARE_LSB 22
`define PSLC_LOCK_FINE 3'h5
`define PSLC_LOCK_COARSE 3'h3
`define PSLC_PRESC_SMALL 6'h10
`define PSLC_PRESC_LARGE 6'h20

`define PSLC_OFS_WORD 12'h000
`define PSLC_OFS_STATUS 12'h004
`define PSLC_OFS_HALF 12'h008
`define PSLC_ST_BUSY 0
`define PSLC_ST_REFUSED 1
`define PSLC_ST_SEQ_LSB 2

`define PSLC_PCLK_MHZ 200
`define PSLC_SCLK_MAX_MHZ 20
`define PSLC_HALF_MIN ((`PSLC_PCLK_MHZ + 2 * `PSLC_SCLK_MAX_MHZ - 1) / (2 * `PSLC_SCLK_MAX_MHZ))

`endif

// >>> src/pslc_pkg.sv
/*
  Types shared by both ends of the serial programming port.
  Assumes pslc_consts.svh on the include path.
*/
`include "pslc_consts.svh"

package pslc_pkg;

  typedef enum logic [1:0] {
    PSLC_IDLE,
    PSLC_SHIFT,
    PSLC_LATCH
  } pslc_host_state_t;

  typedef struct packed {
    logic [23:0] shreg;
    logic sclk_p;
    logic le_p;
    logic [23:0] ctrl;
    logic [23:0] fb;
    logic [23:0] ref_w;
    logic gain;
    logic [17:0] fb_div;
    logic [2:0] lock_cycles;
    logic main_legal;
    logic ref_legal;
  } pslc_dev_st_t;

  typedef struct packed {
    pslc_host_state_t state;
    logic [23:0] word;
    logic [4:0] bit_idx;
    logic [7:0] half;
    logic [7:0] cnt;
    logic sclk;
    logic sdata;
    logic le;
    logic refused;
    logic [1:0] seq;
    logic [31:0] prdata;
    logic pslverr;
  } pslc_host_st_t;

endpackage

// >>> src/pslc_if.sv
/*
  Three-wire link between the host controller and the synthesizer port.
  Assumes both ends run on the same pclk; all wires are driven by the host.
*/
`timescale 1ns/1ps
`default_nettype none

interface pslc_if;
  logic sclk;
  logic sdata;
  logic load_strobe;

  modport host (output sclk, output sdata, output load_strobe);
  modport dev (input sclk, input sdata, input load_strobe);
endinterface

`default_nettype wire

// >>> src/pslc_dev.sv
/*
  Synthesizer end of the serial programming port: shift register, latch
  decode and the programmed fields. Assumes link pins synchronous to pclk
  and a serial clock no faster than pclk / 10.
*/
// Functional notes
// R1 - Counter reset bit holds all dividers
// R2 - Select 10 loads feedback divider latch
// R3 - Select 01 loads reference divider latch
// R4 - Swallow count five bits, 0 to 31
// R5 - Host writes zero to feedback spare bit
// R6 - Main count 13 bits, legal from 3
// R7 - Division equals modulus times main plus swallow
// R8 - Feedback bit 21 picks pump current
// R9 - Gain bit follows latest writer
// R10 - Feedback bit 22 enables output halving
// R11 - Feedback bit 23 picks prescaler source
// R12 - Reference ratio 14 bits, nonzero
// R13 - Reference bits 17:16 set antibacklash
// R14 - Lock needs five or three cycles
// R15 - Test bit zero ignores test latch
// R16 - Band select clock divider from field
// R17 - Host writes zero to reference spares
// R18 - Shift on serial clock, load on strobe
// R19 - Host serial clock at most 20 MHz
// R20 - Strobe low, three bytes, strobe high
// R21 - Select 00 loads control latch
// R22 - Program reference, control, then feedback
// R23 - Most significant bit first, select last
// R24 - Latch holds until addressed word loads
`timescale 1ns/1ps
`default_nettype none
`include "pslc_consts.svh"

module pslc_dev
  import pslc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pslc_if.dev link,
  output logic [23:0] ctrl_word,
  output logic [23:0] fb_word,
  output logic [23:0] ref_word,
  output logic counters_held,
  output logic cp_gain,
  output logic [4:0] swallow_count,
  output logic [12:0] main_count,
  output logic main_count_legal,
  output logic out_div2_en,
  output logic presc_from_half,
  output logic [17:0] feedback_div,
  output logic [13:0] ref_ratio,
  output logic ref_ratio_legal,
  output logic [1:0] abp_width,
  output logic [2:0] lock_cycles,
  output logic test_latch_used,
  output logic [1:0] band_clk_div
);

  pslc_dev_st_t st_q;
  pslc_dev_st_t st_d;

  function automatic logic [5:0] presc_mod(input logic [1:0] p);
    presc_mod = (p == 2'h0) ? `PSLC_PRESC_SMALL : `PSLC_PRESC_LARGE;
  endfunction

  function automatic logic [12:0] main_of(input logic [23:0] w);
    main_of = w[`PSLC_FB_MAIN_LSB +: 13];
  endfunction

  function automatic logic [4:0] swallow_of(input logic [23:0] w);
    swallow_of = w[`PSLC_FB_SWALLOW_LSB +: 5];
  endfunction

  function automatic logic [13:0] ratio_of(input logic [23:0] w);
    ratio_of = w[`PSLC_REF_RATIO_LSB +: 14];
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.sclk_p = link.sclk;
    st_d.le_p = link.load_strobe;
    // R18 shift on rise
    // R23 newest bit enters at bit 0
    if (link.sclk && !st_q.sclk_p) begin
      st_d.shreg = {st_q.shreg[22:0], link.sdata};
    end
    // R18 load on strobe rise
    // R24 only the addressed latch changes
    if (link.load_strobe && !st_q.le_p) begin
      case (st_q.shreg[1:0])
        // R21 control latch
        `PSLC_SEL_CTRL: begin
          st_d.ctrl = st_q.shreg;
          // R9 gain from control word
          st_d.gain = st_q.shreg[`PSLC_CTRL_GAIN];
        end
        // R3 reference latch
        `PSLC_SEL_REF: begin
          st_d.ref_w = st_q.shreg;
        end
        // R2 feedback latch
        `PSLC_SEL_FB: begin
          st_d.fb = st_q.shreg;
          // R8 gain from feedback word
          st_d.gain = st_q.shreg[`PSLC_FB_GAIN];
        end
        default: begin
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end
    // R7 total feedback division
    st_d.fb_div = 18'(presc_mod(st_d.ctrl[`PSLC_CTRL_PRESC_LSB +: 2])) * 18'(main_of(st_d.fb))
      + 18'(swallow_of(st_d.fb));
    // R6 main count lower bound
    st_d.main_legal = main_of(st_d.fb) >= `PSLC_MAIN_MIN;
    // R12 zero ratio illegal
    st_d.ref_legal = ratio_of(st_d.ref_w) != 14'h0000;
    // R14 lock cycle count
    st_d.lock_cycles = st_d.ref_w[`PSLC_REF_LOCK_PREC] ? `PSLC_LOCK_FINE : `PSLC_LOCK_COARSE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.le_p <= 1'b1;
      st_q.lock_cycles <= `PSLC_LOCK_COARSE;
    end else begin
      st_q <= st_d;
    end
  end

  assign ctrl_word = st_q.ctrl;
  assign fb_word = st_q.fb;
  assign ref_word = st_q.ref_w;
  // R1 dividers held in reset
  assign counters_held = st_q.ctrl[`PSLC_CTRL_CNT_RST];
  // R9 single shared gain bit
  assign cp_gain = st_q.gain;
  // R4 five-bit swallow count
  assign swallow_count = swallow_of(st_q.fb);
  assign main_count = main_of(st_q.fb);
  assign main_count_legal = st_q.main_legal;
  // R10 output halving
  assign out_div2_en = st_q.fb[`PSLC_FB_DIV2];
  // R11 prescaler source
  assign presc_from_half = st_q.fb[`PSLC_FB_HALF_SRC];
  assign feedback_div = st_q.fb_div;
  assign ref_ratio = ratio_of(st_q.ref_w);
  assign ref_ratio_legal = st_q.ref_legal;
  // R13 antibacklash width
  assign abp_width = st_q.ref_w[`PSLC_REF_ABP_LSB +: 2];
  assign lock_cycles = st_q.lock_cycles;
  // R15 test latch only when set
  assign test_latch_used = st_q.ref_w[`PSLC_REF_TEST];
  // R16 band select clock divider
  assign band_clk_div = st_q.ref_w[`PSLC_REF_BSC_LSB +: 2];

endmodule

`default_nettype wire

// >>> src/pslc_host.sv
/*
  Host end of the serial programming port: an APB slave whose word register
  sends one 24-bit latch word over the three-wire link. Assumes APB master
  on pclk; the synthesizer samples the link on pclk.
*/
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pslc_consts.svh"

module pslc_host
  import pslc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pslc_if.host link
);

  pslc_host_st_t st_q;
  pslc_host_st_t st_d;
  logic [23:0] clean;
  logic ok;
  logic wr;
  logic rd;

  assign wr = psel && !penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    clean = pwdata[23:0];
    ok = 1'b1;
    case (pwdata[1:0])
      `PSLC_SEL_FB: begin
        // R5 spare bit forced low
        clean[`PSLC_FB_SPARE] = 1'b0;
        // R6 refuse main count below 3
        ok = pwdata[`PSLC_FB_MAIN_LSB +: 13] >= `PSLC_MAIN_MIN;
        // R22 feedback only after control
        ok = ok && (st_q.seq >= 2'h2);
      end
      `PSLC_SEL_REF: begin
        // R17 spares forced low
        clean[`PSLC_REF_SPARE_LSB +: 2] = 2'h0;
        // R15 test bit forced low
        clean[`PSLC_REF_TEST] = 1'b0;
        // R12 refuse zero ratio
        ok = pwdata[`PSLC_REF_RATIO_LSB +: 14] != 14'h0000;
      end
      `PSLC_SEL_CTRL: begin
        // R22 control only after reference
        ok = st_q.seq >= 2'h1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.pslverr = 1'b0;
    st_d.prdata = 32'h00000000;
    if (rd) begin
      case (paddr)
        `PSLC_OFS_WORD: st_d.prdata = {8'h00, st_q.word};
        `PSLC_OFS_STATUS: st_d.prdata = {28'h0000000, st_q.seq, st_q.refused, st_q.state != PSLC_IDLE};
        `PSLC_OFS_HALF: st_d.prdata = {24'h000000, st_q.half};
        default: st_d.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        `PSLC_OFS_WORD: begin
          if (st_q.state != PSLC_IDLE) begin
            st_d.pslverr = 1'b1;
          end else if (!ok) begin
            st_d.refused = 1'b1;
          end else begin
            // R20 strobe low, start shifting
            // R23 most significant bit first
            st_d.word = clean;
            st_d.le = 1'b0;
            st_d.sdata = clean[23];
            st_d.bit_idx = 5'h17;
            st_d.cnt = st_q.half;
            st_d.state = PSLC_SHIFT;
          end
        end
        `PSLC_OFS_STATUS: begin
          if (pwdata[`PSLC_ST_REFUSED]) begin
            st_d.refused = 1'b0;
          end
        end
        `PSLC_OFS_HALF: begin
          // R19 clamp serial clock rate
          st_d.half = (pwdata[7:0] < 8'(`PSLC_HALF_MIN)) ? 8'(`PSLC_HALF_MIN) : pwdata[7:0];
        end
        default: st_d.pslverr = 1'b1;
      endcase
    end
    case (st_q.state)
      PSLC_IDLE: begin
        st_d.sclk = 1'b0;
      end
      PSLC_SHIFT: begin
        if (st_q.cnt > 8'h01) begin
          st_d.cnt = st_q.cnt - 8'h01;
        end else begin
          st_d.cnt = st_q.half;
          st_d.sclk = !st_q.sclk;
          // R18 data moves at each fall but the last
          if (st_q.sclk) begin
            if (st_q.bit_idx == 5'h00) begin
              st_d.state = PSLC_LATCH;
            end else begin
              st_d.bit_idx = st_q.bit_idx - 5'h01;
              st_d.sdata = st_q.word[st_q.bit_idx - 5'h01];
            end
          end
        end
      end
      PSLC_LATCH: begin
        if (st_q.cnt > 8'h01) begin
          st_d.cnt = st_q.cnt - 8'h01;
        end else begin
          // R20 strobe high ends transfer
          st_d.le = 1'b1;
          st_d.state = PSLC_IDLE;
          // R22 track programming order
          case (st_q.word[1:0])
            `PSLC_SEL_REF: st_d.seq = (st_q.seq == 2'h0) ? 2'h1 : st_q.seq;
            `PSLC_SEL_CTRL: st_d.seq = (st_q.seq == 2'h1) ? 2'h2 : st_q.seq;
            default: st_d.seq = 2'h3;
          endcase
        end
      end
      default: st_d.state = PSLC_IDLE;
    endcase
    // Refusal during clear wins
    if (wr && paddr == `PSLC_OFS_WORD && st_q.state == PSLC_IDLE && !ok) begin
      st_d.refused = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.state <= PSLC_IDLE;
      st_q.le <= 1'b1;
      st_q.half <= 8'(`PSLC_HALF_MIN);
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr;
  assign pready = 1'b1;
  assign link.sclk = st_q.sclk;
  assign link.sdata = st_q.sdata;
  assign link.load_strobe = st_q.le;

endmodule

`default_nettype wire

// >>> sim/pslc_assertions.sv
/*
  Link and latch checks for the serial port.
  Assumes one pclk domain, wires from pslc_if.
*/
`timescale 1ns/1ps
`default_nettype none

module pslc_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic [23:0] ctrl_word,
  input wire logic [23:0] fb_word,
  input wire logic [23:0] ref_word,
  input wire logic cp_gain,
  input wire logic counters_held,
  input wire logic [2:0] lock_cycles
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hi; $rose(sclk) |-> sclk [*5]; endproperty
  a_hi: assert property (p_hi) else $error("sclk high too short");
  property p_lo; $fell(sclk) |-> !sclk [*5]; endproperty
  a_lo: assert property (p_lo) else $error("sclk low too short");
  property p_idle; load_strobe |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk outside frame");
  property p_dat;
    $changed(sdata) |-> $fell(sclk) || $fell(load_strobe) || $rose(load_strobe);
  endproperty
  a_dat: assert property (p_dat) else $error("sdata moved near rise");
  property p_fb; $changed(fb_word) |-> $past(load_strobe) && !$past(load_strobe, 4); endproperty
  a_fb: assert property (p_fb) else $error("fb latch moved");
  property p_ref; $changed(ref_word) |-> $past(load_strobe) && !$past(load_strobe, 4); endproperty
  a_ref: assert property (p_ref) else $error("ref latch moved");
  property p_gain; $changed(cp_gain) |-> $past(load_strobe) && !$past(load_strobe, 4); endproperty
  a_gain: assert property (p_gain) else $error("gain moved alone");
  property p_gctl; $changed(ctrl_word) |-> cp_gain == ctrl_word[10]; endproperty
  a_gctl: assert property (p_gctl) else $error("gain not from control word");
  property p_gfb; $changed(fb_word) |-> cp_gain == fb_word[21]; endproperty
  a_gfb: assert property (p_gfb) else $error("gain not from feedback word");
  property p_lock; lock_cycles == (ref_word[18] ? 3'h5 : 3'h3); endproperty
  a_lock: assert property (p_lock) else $error("lock count wrong");
  property p_rst; counters_held == ctrl_word[4]; endproperty
  a_rst: assert property (p_rst) else $error("counter hold wrong");
endmodule

`default_nettype wire

// >>> sim/pll_serial_latch_config_bench.sv
/*
  Bench: APB host end drives the device end over pslc_if.
  Assumes pslc_consts.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pslc_consts.svh"

module pll_serial_latch_config_bench;
  localparam logic [23:0] RW = 24'h36FFFD;
  localparam logic [23:0] CW = 24'h000410;
  localparam logic [23:0] FW = 24'hC0037E;
  localparam logic [23:0] CW2 = 24'h400400;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ch, cg, ml, d2, ph, rl, tl, sp = 1'b0, lp = 1'b1;
  logic [23:0] cw, fw, rw, mw;
  logic [4:0] sw;
  logic [12:0] mc;
  logic [17:0] fd;
  logic [13:0] rr;
  logic [1:0] ab, bc;
  logic [2:0] lc;
  int err_count = 0, compares = 0, mcnt = 0;
  pslc_if lk();
  pslc_host pslc_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lk));
  pslc_dev pslc_dev_inst(.pclk(pclk), .presetn(presetn), .link(lk), .ctrl_word(cw),
    .fb_word(fw), .ref_word(rw), .counters_held(ch), .cp_gain(cg), .swallow_count(sw),
    .main_count(mc), .main_count_legal(ml), .out_div2_en(d2), .presc_from_half(ph),
    .feedback_div(fd), .ref_ratio(rr), .ref_ratio_legal(rl), .abp_width(ab),
    .lock_cycles(lc), .test_latch_used(tl), .band_clk_div(bc));
  pslc_assertions pslc_assertions_inst(.pclk(pclk), .presetn(presetn), .sclk(lk.sclk),
    .sdata(lk.sdata), .load_strobe(lk.load_strobe), .ctrl_word(cw), .fb_word(fw),
    .ref_word(rw), .cp_gain(cg), .counters_held(ch), .lock_cycles(lc));
  initial forever #2.5 pclk = ~pclk;
  // Wire monitor: bits seen at sclk rises
  always @(posedge pclk) begin
    sp <= lk.sclk;
    lp <= lk.load_strobe;
    if (lp && !lk.load_strobe) mcnt <= 0;
    else if (!lk.load_strobe && lk.sclk && !sp) begin
      mw <= {mw[22:0], lk.sdata};
      mcnt <= mcnt + 1;
    end
  end
  task end_sim;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task idle;
    do begin apb(1'b0, `PSLC_OFS_STATUS, 32'h0); end while (rd[0] !== 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, `PSLC_OFS_STATUS, 32'h0);
  endtask
  task send(input logic [23:0] w);
    apb(1'b1, `PSLC_OFS_WORD, {8'h00, w});
    idle();
  endtask
  task t_reset;
    chk(lc, 32'h3);
    chk(cw, 32'h0);
    apb(1'b0, `PSLC_OFS_HALF, 32'h0);
    chk(rd, 32'h5);
  endtask
  task t_order;
    send(FW);
    chk(fw, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, `PSLC_OFS_STATUS, 32'h2);
  endtask
  task t_ref;
    send(RW);
    chk(mw, RW);
    chk(mcnt, 32'h18);
    chk(rw, RW);
    chk(rr, 32'h3FFF);
    chk(rl, 32'h1);
    chk(ab, 32'h2);
    chk(lc, 32'h5);
    chk(bc, 32'h3);
    chk(tl, 32'h0);
    chk(rd, 32'h4);
  endtask
  task t_ctrl;
    send(CW);
    chk(cw, CW);
    chk(ch, 32'h1);
    chk(cg, 32'h1);
    chk(rw, RW);
  endtask
  task t_fb;
    send(FW);
    chk(mw, FW);
    chk(fw, FW);
    chk(sw, 32'h1F);
    chk(mc, 32'h3);
    chk(ml, 32'h1);
    chk(fd, 32'h4F);
    chk(cg, 32'h0);
    chk(d2, 32'h1);
    chk(ph, 32'h1);
    chk(cw, CW);
  endtask
  task t_spare;
    send(FW | 24'h000080);
    chk(fw, FW);
    chk(mw, FW);
    apb(1'b1, `PSLC_OFS_WORD, {8'h00, RW | 24'hC80000});
    apb(1'b1, `PSLC_OFS_WORD, 32'h0);
    chk(er, 32'h1);
    idle();
    chk(rw, RW);
    chk(mw, RW);
    send(CW2);
    chk(ch, 32'h0);
    chk(cg, 32'h1);
    chk(fd, 32'h7F);
  endtask
  task t_refuse;
    send(24'h200202);
    chk(fw, FW);
    chk(rd[1], 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_order();
    t_ref();
    t_ctrl();
    t_fb();
    t_spare();
    t_refuse();
    end_sim();
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
endmodule

`default_nettype wire
